//--- src/vcq_pkg.sv
// Purpose: Shared constants for the volatile configuration register block
// Assumes: Serial register commands arrive single lane, SPI mode 0
// Notes:   Register addresses below are local choices for this block

package vcq_pkg;

    // ------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] VCQ_OPC_READ_ANY = 8'h65; // Read any register
    localparam logic [7:0] VCQ_OPC_WRITE_ANY = 8'h71; // Write any register

    // ------------------------------------------------------------
    // Register address map
    // ------------------------------------------------------------
    localparam int VCQ_ADDR_BYTES = 3; // Address length in bytes
    localparam logic [23:0] VCQ_ADDR_VCFG1 = 24'h000102; // Volatile config one

    // ------------------------------------------------------------
    // Field positions of the volatile configuration register
    // ------------------------------------------------------------
    localparam int VCQ_BIT_FREEZE = 0; // Protection lock
    localparam int VCQ_BIT_QUAD = 1; // Four-lane data width
    localparam int VCQ_BIT_PARAM_LOC = 2; // Parameter location shadow
    localparam int VCQ_BIT_PROT_SEL = 3; // Protect select shadow
    localparam int VCQ_BIT_PROT_START = 5; // Protect start shadow

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] VCQ_BYTE_ZERO = 8'h00; // Reserved and idle value
    localparam int VCQ_DUMMY_BYTES = 1; // Read latency, eight cycles
    localparam int VCQ_SYNC_STAGES = 2; // Pin synchroniser depth
    localparam int VCQ_PIN_COUNT = 5; // Sampled pins

    // Pin order inside the synchroniser bank
    localparam int VCQ_PIN_SCK = 0;
    localparam int VCQ_PIN_CS = 1;
    localparam int VCQ_PIN_SI = 2;
    localparam int VCQ_PIN_WP = 3;
    localparam int VCQ_PIN_IO3 = 4;

    // Command decoder states
    typedef enum logic [2:0] {
        VCQ_ST_IDLE,
        VCQ_ST_OPCODE,
        VCQ_ST_ADDR,
        VCQ_ST_DUMMY,
        VCQ_ST_RDATA,
        VCQ_ST_WDATA,
        VCQ_ST_IGNORE
    } vcq_state_e;

endpackage

//--- src/vcq_link_if.sv
// Purpose: Carrier between the serial front end and the register core
// Assumes: Both ends run on the system clock
// Notes:   All signals are already synchronised to clk

`timescale 1ns/100ps

interface vcq_link_if;
    logic frame_act; // Chip select low, synchronised
    logic frame_end; // Pulse on chip select rising
    logic byte_stb; // Pulse, one received byte complete
    logic [7:0] rx_byte; // Received byte, valid with byte_stb
    logic tx_load; // Pulse, load a byte for output
    logic [7:0] tx_byte; // Byte to send, valid with tx_load
    logic wp_n_s; // Synchronised write-protect pin
    logic io3_s; // Synchronised reset-capable pin

    // Serial front end
    modport phy (
        output frame_act, frame_end, byte_stb, rx_byte, wp_n_s, io3_s,
        input tx_load, tx_byte
    );

    // Register core
    modport core (
        input frame_act, frame_end, byte_stb, rx_byte, wp_n_s, io3_s,
        output tx_load, tx_byte
    );
endinterface

//--- src/vcq_spi_phy.sv
// Purpose: Serial front end, samples pins and shifts bytes in and out
// Assumes: SPI mode 0, serial clock well below a quarter of clk
// Notes:   Output changes one sync delay after each falling serial edge but the one that ends the load byte

`timescale 1ns/100ps

module vcq_spi_phy
    import vcq_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic sck, // Serial clock pin
    input wire logic cs_n, // Chip select pin, active low
    input wire logic si, // Serial data in
    input wire logic wp_n, // Write-protect pin, data line two
    input wire logic io3, // Reset-capable pin, data line three
    output logic so, // Serial data out
    output logic so_oe, // Output enable for so
    vcq_link_if.phy link // Toward the register core
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [VCQ_PIN_COUNT-1:0] pins; // Raw pin vector
    logic [VCQ_PIN_COUNT-1:0] sync_q [VCQ_SYNC_STAGES]; // Sync chain
    logic [VCQ_PIN_COUNT-1:0] seen_q; // Previous synced value
    assign pins = {io3, wp_n, si, cs_n, sck};

    // Each pin gets its own two-stage chain; only stage two is read
    genvar g;
    generate
        for (g = 0; g < VCQ_SYNC_STAGES; g++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync_q[g] <= '1;
                end else begin
                    sync_q[g] <= (g == 0) ? pins : sync_q[(g == 0) ? 0 : g-1];
                end
            end
        end
    endgenerate

    // Delayed copy for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_q <= '1;
        end else begin
            seen_q <= sync_q[VCQ_SYNC_STAGES-1];
        end
    end

    // ------------------------------------------------------------
    // Edge decode
    // ------------------------------------------------------------
    wire [VCQ_PIN_COUNT-1:0] cur = sync_q[VCQ_SYNC_STAGES-1]; // Synced pins
    wire act = !cur[VCQ_PIN_CS]; // Frame active
    wire sck_rise = act && cur[VCQ_PIN_SCK] && !seen_q[VCQ_PIN_SCK];
    wire sck_fall = act && !cur[VCQ_PIN_SCK] && seen_q[VCQ_PIN_SCK];
    wire cs_rise = cur[VCQ_PIN_CS] && !seen_q[VCQ_PIN_CS];

    // ------------------------------------------------------------
    // Receive shifter
    // ------------------------------------------------------------
    logic [7:0] rx_q; // Receive shift register
    logic [2:0] bit_q; // Bit count inside a byte
    logic stb_q; // Byte complete pulse
    logic end_q; // Frame end pulse

    // Bits are taken on rising serial edges, count restarts per frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_q <= VCQ_BYTE_ZERO;
            bit_q <= '0;
            stb_q <= 1'b0;
        end else if (!act) begin
            bit_q <= '0;
            stb_q <= 1'b0;
        end else begin
            stb_q <= sck_rise && (bit_q == 3'h7);
            if (sck_rise) begin
                rx_q <= {rx_q[6:0], cur[VCQ_PIN_SI]};
                bit_q <= bit_q + 3'h1;
            end
        end
    end

    // Chip select rise closes the frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            end_q <= 1'b0;
        end else begin
            end_q <= cs_rise;
        end
    end

    // ------------------------------------------------------------
    // Transmit shifter
    // ------------------------------------------------------------
    logic [7:0] tx_q; // Transmit shift register
    logic hold_q; // Skip the falling edge that ends the load byte

    // A load places the first bit at once; later falling edges shift
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_q <= VCQ_BYTE_ZERO;
            hold_q <= 1'b0;
            so <= 1'b0;
            so_oe <= 1'b0;
        end else if (!act) begin
            hold_q <= 1'b0;
            so_oe <= 1'b0;
        end else if (link.tx_load) begin
            tx_q <= {link.tx_byte[6:0], 1'b0};
            so <= link.tx_byte[7];
            so_oe <= 1'b1;
            hold_q <= 1'b1;
        end else if (sck_fall) begin
            if (hold_q) begin
                hold_q <= 1'b0;
            end else begin
                so <= tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    assign link.frame_act = act;
    assign link.frame_end = end_q;
    assign link.byte_stb = stb_q;
    assign link.rx_byte = rx_q;
    assign link.wp_n_s = cur[VCQ_PIN_WP];
    assign link.io3_s = cur[VCQ_PIN_IO3];

    // Output pin must release soon after chip select rises
    a_so_release: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(cur[VCQ_PIN_CS]) |=> !so_oe)
        else $error("so_oe still high after frame end");

endmodule

//--- src/vcq_volatile_cfg.sv
// Purpose: Volatile configuration register one with quad width and lock
// Assumes: Non-volatile store and otp logic sit outside on the same clock
// Notes:   Shadow bits are read live from the non-volatile image

`timescale 1ns/100ps

module vcq_volatile_cfg
    import vcq_pkg::*;
(
    input wire logic clk, // System clock, 40 MHz
    input wire logic rst_n, // Power-on reset, async, active low
    input wire logic sck, // Serial clock pin
    input wire logic cs_n, // Chip select pin, active low
    input wire logic si, // Serial data in pin
    input wire logic wp_n, // Write-protect pin, data line two in quad
    input wire logic io3, // Reset pin, data line three in quad
    output logic so, // Serial data out pin
    output logic so_oe, // Output enable for so
    input wire logic [7:0] nv_config_one, // Non-volatile config image
    input wire logic nv_quad_wr, // Pulse, non-volatile quad bit written
    input wire logic io3_reset_en, // Reset function of io3 enabled
    input wire logic qpi_mode, // Four-lane instruction mode active
    input wire logic sw_reset, // Pulse, software reset
    input wire logic otp_prog_req, // Pulse, otp program attempt
    input wire logic otp_in_area, // Program address inside otp area
    output logic quad_mode_q, // Four-lane data width selected
    output logic freeze_q, // Protection lock, protect bits frozen
    output logic wp_n_eff_q, // Write-protect level seen inside
    output logic hw_reset_q, // Hardware reset from io3, high while io3 is held low outside a quad frame
    output logic otp_prog_ok_q, // Pulse, otp program may proceed
    output logic prog_error_set_q // Pulse, set program-error flag
);

    // ------------------------------------------------------------
    // Front end
    // ------------------------------------------------------------
    vcq_link_if link (); // Synced serial events

    vcq_spi_phy u_phy (
        .clk(clk),
        .rst_n(rst_n),
        .sck(sck),
        .cs_n(cs_n),
        .si(si),
        .wp_n(wp_n),
        .io3(io3),
        .so(so),
        .so_oe(so_oe),
        .link(link)
    );

    // ------------------------------------------------------------
    // Command decoder
    // ------------------------------------------------------------
    vcq_state_e st_q; // Decoder state
    vcq_state_e st_d; // Next state
    logic [23:0] addr_q; // Collected register address
    logic [1:0] cnt_q; // Address or dummy byte count
    logic rd_q; // Current command is a read
    logic wr_pend_q; // Write waits for frame end
    logic [7:0] wdata_q; // Captured write byte
    logic load_pend_q; // Default load pending after reset

    // Address compare used by both the read and the write path
    function automatic logic hit_vcfg(input logic [23:0] a);
        return a == VCQ_ADDR_VCFG1;
    endfunction

    wire [23:0] addr_next = {addr_q[15:0], link.rx_byte}; // Shift in byte
    wire last_addr = (cnt_q == 2'(VCQ_ADDR_BYTES - 1)); // Final addr byte
    wire last_dummy = (cnt_q == 2'(VCQ_DUMMY_BYTES - 1)); // Final dummy
    wire opc_rd = (link.rx_byte == VCQ_OPC_READ_ANY);
    wire opc_wr = (link.rx_byte == VCQ_OPC_WRITE_ANY);

    // Read image: reserved bits zero, shadows live from the non-volatile image
    wire [7:0] rd_image = {
        2'b00,
        nv_config_one[VCQ_BIT_PROT_START],
        1'b0,
        nv_config_one[VCQ_BIT_PROT_SEL],
        nv_config_one[VCQ_BIT_PARAM_LOC],
        quad_mode_q,
        freeze_q
    };

    // Next-state logic; unknown opcodes sit in VCQ_ST_IGNORE until chip select rises
    always_comb begin
        st_d = st_q;
        if (!link.frame_act) begin
            st_d = VCQ_ST_IDLE;
        end else if (link.byte_stb) begin
            case (st_q)
                VCQ_ST_IDLE, VCQ_ST_OPCODE: begin
                    st_d = (opc_rd || opc_wr) ? VCQ_ST_ADDR : VCQ_ST_IGNORE;
                end
                VCQ_ST_ADDR: begin
                    if (last_addr) begin
                        st_d = rd_q ? VCQ_ST_DUMMY : VCQ_ST_WDATA;
                    end
                end
                VCQ_ST_DUMMY: begin
                    st_d = last_dummy ? VCQ_ST_RDATA : VCQ_ST_DUMMY;
                end
                VCQ_ST_RDATA: begin
                    st_d = VCQ_ST_RDATA;
                end
                VCQ_ST_WDATA: begin
                    st_d = VCQ_ST_IGNORE;
                end
                default: begin
                    st_d = VCQ_ST_IGNORE;
                end
            endcase
        end
    end

    // State and byte counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= VCQ_ST_IDLE;
            cnt_q <= '0;
        end else begin
            st_q <= st_d;
            if (st_d != st_q) begin
                cnt_q <= '0;
            end else if (link.byte_stb) begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

    // Opcode and address capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 1'b0;
            addr_q <= '0;
        end else if (link.byte_stb) begin
            if (st_q == VCQ_ST_IDLE) begin
                rd_q <= opc_rd;
            end
            if (st_q == VCQ_ST_ADDR) begin
                addr_q <= addr_next;
            end
        end
    end

    // Reads reload the image each byte so repeated bytes stay current
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link.tx_load <= 1'b0;
            link.tx_byte <= VCQ_BYTE_ZERO;
        end else begin
            link.tx_load <= link.byte_stb && (st_d == VCQ_ST_RDATA);
            link.tx_byte <= hit_vcfg(addr_q) ? rd_image : VCQ_BYTE_ZERO;
        end
    end

    // A write is only held here; it lands at chip select rise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wdata_q <= VCQ_BYTE_ZERO;
        end else if (link.frame_end) begin
            wr_pend_q <= 1'b0;
        end else if (link.byte_stb && st_q == VCQ_ST_WDATA && hit_vcfg(addr_q)) begin
            wr_pend_q <= 1'b1;
            wdata_q <= link.rx_byte;
        end
    end

    // ------------------------------------------------------------
    // Hardware reset through the reset-capable pin
    // ------------------------------------------------------------
    // The pin is data line three only inside a quad frame
    wire io3_is_reset = !link.frame_act || !quad_mode_q;
    wire hw_rst_req = io3_reset_en && io3_is_reset && !link.io3_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hw_reset_q <= 1'b0;
        end else begin
            hw_reset_q <= hw_rst_req;
        end
    end

    // ------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------
    wire commit = wr_pend_q && link.frame_end;
    // Lock can be raised but never dropped by a write
    wire freeze_wr = freeze_q | wdata_q[VCQ_BIT_FREEZE];
    // Quad is writable under lock; refused clear while qpi is on
    wire quad_keep = qpi_mode && quad_mode_q;
    wire quad_wr = wdata_q[VCQ_BIT_QUAD] | quad_keep;
    wire four_lane_default = nv_config_one[VCQ_BIT_QUAD] | quad_keep;

    // Default load is caught by a clock after reset, never at async time
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_pend_q <= 1'b1;
        end else begin
            load_pend_q <= hw_reset_q;
        end
    end

    // Lock: loaded from default, cleared only by power or hardware reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            freeze_q <= 1'b0;
        end else if (hw_reset_q) begin
            freeze_q <= 1'b0;
        end else if (load_pend_q) begin
            freeze_q <= nv_config_one[VCQ_BIT_FREEZE];
        end else if (commit) begin
            freeze_q <= freeze_wr;
        end
    end

    // Quad width: default on load and software reset, then host writes, else default on nv_quad_wr
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            quad_mode_q <= 1'b0;
        end else if (load_pend_q || sw_reset) begin
            quad_mode_q <= four_lane_default;
        end else if (commit) begin
            quad_mode_q <= quad_wr;
        end else if (nv_quad_wr) begin
            quad_mode_q <= four_lane_default;
        end
    end

    // ------------------------------------------------------------
    // Write-protect pin and otp guard
    // ------------------------------------------------------------
    // In quad the pin carries data, so its level is ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_n_eff_q <= 1'b1;
        end else begin
            wp_n_eff_q <= quad_mode_q | link.wp_n_s;
        end
    end

    // Lock turns an otp program inside the area into an error
    wire otp_blocked = freeze_q && otp_in_area;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            otp_prog_ok_q <= 1'b0;
            prog_error_set_q <= 1'b0;
        end else begin
            otp_prog_ok_q <= otp_prog_req && !otp_blocked;
            prog_error_set_q <= otp_prog_req && otp_blocked;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // A commit that no reset load overrides in the same cycle
    sequence s_write_done;
        commit && !load_pend_q && !hw_reset_q;
    endsequence

    a_freeze_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (freeze_q && !hw_reset_q && !load_pend_q) |=> freeze_q)
        else $error("lock dropped without hardware reset");

    a_hw_clears: assert property (@(posedge clk) disable iff (!rst_n)
        hw_reset_q |=> !freeze_q)
        else $error("hardware reset did not clear lock");

    // Reload happens one edge after the reset request goes away
    a_hw_reload: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(hw_reset_q) |=> (freeze_q == $past(nv_config_one[VCQ_BIT_FREEZE])))
        else $error("lock not reloaded after hardware reset");

    a_qpi_keeps_quad: assert property (@(posedge clk) disable iff (!rst_n)
        (qpi_mode && quad_mode_q) |=> quad_mode_q)
        else $error("quad cleared while qpi active");

    a_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
        (s_write_done ##0 wdata_q[VCQ_BIT_FREEZE]) |=> freeze_q)
        else $error("lock not set by write");

    a_quad_at_end: assert property (@(posedge clk) disable iff (!rst_n)
        (link.frame_act && !load_pend_q && !sw_reset && !nv_quad_wr) |=> $stable(quad_mode_q))
        else $error("quad changed inside a frame");

    a_otp_fail: assert property (@(posedge clk) disable iff (!rst_n)
        (otp_prog_req && freeze_q && otp_in_area) |=> prog_error_set_q && !otp_prog_ok_q)
        else $error("locked otp program not refused");

    a_otp_allow: assert property (@(posedge clk) disable iff (!rst_n)
        (otp_prog_req && !freeze_q) |=> otp_prog_ok_q && !prog_error_set_q)
        else $error("unlocked otp program refused");

    a_wp_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        (quad_mode_q && !link.wp_n_s) |=> wp_n_eff_q)
        else $error("write-protect pin seen in quad");

    a_read_image: assert property (@(posedge clk) disable iff (!rst_n)
        (link.tx_load && hit_vcfg(addr_q)) |->
        (link.tx_byte[7:6] == 2'b00) && !link.tx_byte[4] &&
        (link.tx_byte[VCQ_BIT_PROT_START] == $past(nv_config_one[VCQ_BIT_PROT_START])))
        else $error("read image reserved or shadow bit wrong");

endmodule

//--- testbench/vcq_host_model.sv
// Purpose: Host controller model on the serial pins
// Assumes: Mode 0, serial clock period 200 ns
// Notes: Data in flips between frames so stale bits never pass
`timescale 1ns/100ps
module vcq_host_model (
    input wire logic clk, // System clock
    input wire logic so, // Data from device
    output logic sck, // Serial clock, still outside frames
    output logic cs_n, // Chip select, active low
    output logic si // Data to device
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    // ----
    // Frame engine
    // ----
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Only single-lane commands, so quad is never needed first
    task automatic xfer(input logic [7:0] op, input logic [23:0] a,
                        input logic [7:0] d, output logic [7:0] r);
        logic [39:0] sh;
        int n;
        sh = {op, a, d};
        n = (op == 8'h65) ? 48 : 40;
        r = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = (i < 40) ? sh[39 - i] : ~si;
            tick(4);
            sck = 1'b1;
            // Read byte follows the dummy byte
            if (i >= 40) begin
                r = {r[6:0], so};
            end
            tick(4);
            sck = 1'b0;
        end
        tick(4);
        cs_n = 1'b1;
        si = ~si;
        tick(8);
    endtask
endmodule

//--- testbench/test_volatile_config_quad_freeze.sv
// Purpose: Self-checking bench for the volatile config register
// Assumes: Model state held in m_quad and m_frz
// Notes: Lock can only be cleared here through io3 reset
`timescale 1ns/100ps
module test_volatile_config_quad_freeze;
    import vcq_pkg::*;
    logic clk, rst_n, sck, cs_n, si, wp_n, io3, so, so_oe, nv_quad_wr, io3_reset_en;
    logic qpi_mode, sw_reset, otp_prog_req, otp_in_area, quad_mode_q, freeze_q;
    logic wp_n_eff_q, hw_reset_q, otp_prog_ok_q, prog_error_set_q;
    logic [7:0] nv, rd;
    int fails, n_compared, m_quad, m_frz;
    vcq_volatile_cfg dut (.clk, .rst_n, .sck, .cs_n, .si, .wp_n, .io3, .so, .so_oe,
        .nv_config_one(nv), .nv_quad_wr, .io3_reset_en, .qpi_mode, .sw_reset,
        .otp_prog_req, .otp_in_area, .quad_mode_q, .freeze_q, .wp_n_eff_q,
        .hw_reset_q, .otp_prog_ok_q, .prog_error_set_q);
    vcq_host_model host (.clk, .so, .sck, .cs_n, .si);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ----
    // Compare and model tasks
    // ----
    task automatic chk_bit(input logic g, input int e);
        n_compared++;
        if (g !== e[0]) begin
            fails++;
            $display("CHECK FAILED %0t bit mismatch", $time);
        end
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %0t read %h want %h", $time, g, e);
        end
    endtask
    // Write, then apply lock and quad refusal to the model
    task automatic wr(input logic [7:0] d);
        host.xfer(VCQ_OPC_WRITE_ANY, VCQ_ADDR_VCFG1, d, rd);
        if (m_frz == 0) m_frz = d[0];
        if (!(qpi_mode && m_quad == 1 && !d[1])) m_quad = d[1];
    endtask
    // Read back and compare pins and register image
    task automatic st();
        host.xfer(VCQ_OPC_READ_ANY, VCQ_ADDR_VCFG1, 8'($urandom), rd);
        chk_byte(rd, {2'b00, nv[5], 1'b0, nv[3:2], 1'(m_quad), 1'(m_frz)});
        chk_bit(quad_mode_q, m_quad);
        chk_bit(freeze_q, m_frz);
        chk_bit(so_oe, 0);
    endtask
    task automatic otp(input logic area, input int e);
        otp_in_area = area;
        otp_prog_req = 1'b1;
        host.tick(1);
        otp_prog_req = 1'b0;
        chk_bit(prog_error_set_q, e);
        chk_bit(otp_prog_ok_q, 1 - e);
    endtask
    task automatic test_done();
        if (fails == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #2ms;
        fails++;
        test_done();
    end
    // ----
    // Main sequence
    // ----
    initial begin
        void'($urandom(41));
        {rst_n, nv_quad_wr, qpi_mode, sw_reset, otp_prog_req} = 5'h00;
        {wp_n, io3} = 2'h3;
        io3_reset_en = 1'($urandom);
        otp_in_area = 1'($urandom);
        nv = (8'($urandom) & 8'hEC) | 8'h01;
        m_frz = 1;
        m_quad = 0;
        host.tick(10);
        rst_n = 1'b1;
        host.tick(6);
        st();
        wr(8'($urandom) | 8'h02 & 8'hFE);
        st();
        otp(1'b1, 1);
        otp(1'b0, 0);
        sw_reset = 1'b1;
        host.tick(1);
        sw_reset = 1'b0;
        m_quad = 0;
        host.tick(4);
        st();
        nv = nv & 8'hFC;
        {io3_reset_en, io3, wp_n} = 3'h4;
        host.tick(8);
        chk_bit(hw_reset_q, 1);
        io3 = 1'b1;
        host.tick(10);
        chk_bit(hw_reset_q, 0);
        m_frz = 0;
        st();
        chk_bit(wp_n_eff_q, 0);
        otp(1'b1, 0);
        wp_n = 1'($urandom);
        wr(8'h02);
        st();
        chk_bit(wp_n_eff_q, 1);
        qpi_mode = 1'b1;
        wr(8'h00);
        st();
        qpi_mode = 1'($urandom);
        wr(8'($urandom) | 8'h01 & 8'hFD);
        st();
        nv[1] = 1'b1;
        nv_quad_wr = 1'b1;
        host.tick(1);
        nv_quad_wr = 1'b0;
        m_quad = 1;
        host.tick(2);
        st();
        host.xfer(VCQ_OPC_WRITE_ANY, 24'h000000, 8'h00, rd);
        st();
        test_done();
    end
endmodule
